// ==== verilog/io_chan_defs.svh ====
// offsets, field positions, reset values and timing figures of the io channel block
`ifndef IO_CHAN_DEFS_SVH
`define IO_CHAN_DEFS_SVH

// pointer byte modes, upper nibble
`define MODE_CONFIG      4'h0
`define MODE_DAC_WRITE   4'h1
`define MODE_ADC_RB      4'h4
`define MODE_DAC_RB      4'h5
`define MODE_GPIO_RB     4'h6
`define MODE_REG_RB      4'h7

// control register indices, lower nibble in config mode
`define REG_ADC_SEQ      4'h2
`define REG_GP_CTRL      4'h3
`define REG_ADC_CFG      4'h4
`define REG_DAC_CFG      4'h5
`define REG_DEFER        4'h7
`define REG_GPO_CFG      4'h8
`define REG_GPO_DATA     4'h9
`define REG_GPI_CFG      4'ha
`define REG_PD_REF       4'hb
`define REG_SOFT_RESET   4'hf

`define SOFT_RESET_KEY   16'h0dac

// field positions
`define GP_DAC_RANGE_BIT 4
`define GP_ADC_RANGE_BIT 5
`define GP_LOCK_BIT      7
`define SEQ_TEMP_BIT     8
`define PD_REF_EN_BIT    9

// deferred update modes
`define DEFER_IMMEDIATE  2'h0
`define DEFER_HOLD       2'h1
`define DEFER_LOAD_ALL   2'h2

`define TEMP_CHAN_ID     4'h8

// reset values
`define REG16_RESET      16'h0000
`define REG8_RESET       8'h00

// timing
`define CLK_PERIOD_NS    100
`define ACQ_MIN_NS       500
`define CONV_NS          2000
`define TEMP_CONV_NS     5000

`endif

// ==== verilog/io_chan_pkg.sv ====
// types shared by the io channel control block
package io_chan_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_TRACK,
        SEQ_CONVERT
    } seq_state_t;

    typedef logic [11:0] dac_code_t;

endpackage : io_chan_pkg

// ==== verilog/configurable_io_channel_control.sv ====
// control logic of an eight-pin configurable dac / adc / gpio port
`timescale 1ns/10ps
`default_nettype none
`include "io_chan_defs.svh"

// Summary of operation
// RQ1: one dac range bit sets span of all eight dac channels together
// RQ2: dac codes are unsigned straight binary, 0 to 4095
// RQ3: without deferral a dac write reaches its output right after the write
// RQ4: deferred mode holds written codes until a load-all write updates all
// RQ5: host selects converted channels with a bitmask in the sequence register
// RQ6: sequence register write puts first selected channel into track
// RQ7: each sequenced channel tracks at least 500 ns before converting
// RQ8: conversion starts on the ack after the read slave address
// RQ9: sequencer steps mux to next selected channel; 12-bit, 2 us each; the temperature slot converts for 5 us instead
// RQ10: one adc range bit sets input span of all adc channels
// RQ11: adc results are unsigned straight binary
// RQ12: pin set as dac and adc stays a dac output but is converted
// RQ13: gpio input and output config bits make pins digital in or out
// RQ14: digital output pins follow the gpio output data register
// RQ15: host reads pin states with pointer byte 0b01100000
// RQ16: pins set both output and input show their state on readback
// RQ17: reference off after reset, on when enable bit 9 written one
// RQ18: falling edge on reset pin restores all registers and pin defaults
// RQ19: host waits up to 250 us after any reset before writing
// RQ20: host sends pointer 0x0f then 0x0d and 0xac for software reset
// RQ21: correct software reset key acts exactly like the reset pin
// RQ22: pointer upper nibble is the mode, lower nibble the selection
// RQ23: every write carries a pointer byte and two data bytes
// RQ24: with lock bit set, pin configuration writes are ignored
// RQ25: temperature bit appends a die temperature conversion, id 0b1000
// RQ26: each adc result word carries its channel identifier
// RQ27: an applied dac code stays until a new write or reset
module configurable_io_channel_control
    import io_chan_pkg::*;
#(
    parameter int NUM_CH = 8
) (
    // clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_srst,
    input  wire logic                 i_reset_pin_n,
    // serial transfers, decoded
    input  wire logic                 i_wr_valid,
    input  wire logic [7:0]           i_wr_ptr,
    input  wire logic [15:0]          i_wr_data,
    input  wire logic                 i_ptr_valid,
    input  wire logic [7:0]           i_ptr,
    input  wire logic                 i_rd_addr_ack,
    output logic      [15:0]          o_rd_data,
    // io channel pins
    input  wire logic [NUM_CH-1:0]    i_pin_in,
    output logic      [NUM_CH-1:0]    o_pin_out,
    output logic      [NUM_CH-1:0]    o_pin_oe,
    output logic      [NUM_CH-1:0]    o_pin_pulldown,
    // dac side
    output logic      [NUM_CH-1:0]    o_dac_en,
    output logic      [NUM_CH*12-1:0] o_dac_code,
    output logic                      o_dac_gain2,
    // adc side
    output logic      [3:0]           o_adc_mux,
    output logic                      o_adc_track,
    output logic                      o_adc_convert,
    output logic                      o_adc_gain2,
    input  wire logic [11:0]          i_adc_code,
    // reference
    output logic                      o_ref_en
);

    localparam int ACQ_CYC =
        (`ACQ_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int CONV_CYC  = `CONV_NS / `CLK_PERIOD_NS;
    localparam int TEMP_CYC  = `TEMP_CONV_NS / `CLK_PERIOD_NS;

    logic [15:0]         gp_ctrl_r;
    logic [15:0]         pd_ref_r;
    logic [8:0]          adc_seq_r;
    logic [NUM_CH-1:0]   adc_cfg_r;
    logic [NUM_CH-1:0]   dac_cfg_r;
    logic [NUM_CH-1:0]   gpo_cfg_r;
    logic [NUM_CH-1:0]   gpo_data_r;
    logic [NUM_CH-1:0]   gpi_cfg_r;
    logic [1:0]          defer_r;
    dac_code_t           dac_in_r  [NUM_CH];
    dac_code_t           dac_out_r [NUM_CH];
    logic [7:0]          rd_ptr_r;
    logic [15:0]         adc_res_r;
    logic                reset_pin_q_r;
    seq_state_t          seq_state_r;
    logic [3:0]          cur_ch_r;
    logic [7:0]          trk_cnt_r;
    logic [7:0]          conv_cnt_r;
    logic                start_pend_r;

    logic                cfg_wr;
    logic [3:0]          idx;
    logic                locked;
    logic                sw_key;
    logic                pin_fall;
    logic                reset_all;
    logic                dac_wr;
    logic [2:0]          wr_ch;
    logic                load_all;
    logic                seq_wr;
    logic                trk_done;
    logic                conv_start;
    logic                conv_end;
    logic [7:0]          conv_len;
    logic [15:0]         rd_data_nxt;

    // next selected channel after cur, wrapping; channel 8 is temperature
    function automatic logic [3:0] next_chan(input logic [8:0] mask,
                                             input logic [3:0] cur);
        logic [3:0] res;
        logic       found;
        int         j;
        res   = cur;
        found = 1'b0;
        for (int i = 1; i <= 9; i++) begin
            j = (int'(cur) + i) % 9;
            if (!found && mask[j]) begin
                res   = 4'(j);
                found = 1'b1;
            end
        end
        return res;
    endfunction : next_chan

    // reset pin, software key and core reset all restore defaults
    assign pin_fall  = reset_pin_q_r & ~i_reset_pin_n;          // RQ18
    assign cfg_wr    = i_wr_valid && i_wr_ptr[7:4] == `MODE_CONFIG; // RQ22
    assign idx       = i_wr_ptr[3:0];
    assign sw_key    = cfg_wr && idx == `REG_SOFT_RESET &&
                       i_wr_data == `SOFT_RESET_KEY;             // RQ21
    assign reset_all = i_srst | pin_fall | sw_key;
    assign locked    = gp_ctrl_r[`GP_LOCK_BIT];
    assign dac_wr    = i_wr_valid && i_wr_ptr[7:4] == `MODE_DAC_WRITE;
    assign wr_ch     = i_wr_ptr[2:0];
    assign load_all  = cfg_wr && idx == `REG_DEFER &&
                       i_wr_data[1:0] == `DEFER_LOAD_ALL;        // RQ4
    assign seq_wr    = cfg_wr && idx == `REG_ADC_SEQ;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            reset_pin_q_r <= 1'b1;
        end else begin
            reset_pin_q_r <= i_reset_pin_n;
        end
    end

    // general control, reference and deferral registers
    always_ff @(posedge i_core_clk) begin
        if (reset_all) begin
            gp_ctrl_r <= `REG16_RESET;
            pd_ref_r  <= `REG16_RESET;                           // RQ17
            defer_r   <= `DEFER_IMMEDIATE;
        end else if (cfg_wr) begin
            if (idx == `REG_GP_CTRL) begin
                gp_ctrl_r <= i_wr_data;                          // RQ1 RQ10
            end
            if (idx == `REG_PD_REF) begin
                pd_ref_r <= i_wr_data;                           // RQ17
            end
            if (idx == `REG_DEFER && !load_all) begin
                defer_r <= i_wr_data[1:0];
            end
        end
    end

    // pin configuration, ignored while locked; gpio output data, written even while locked
    always_ff @(posedge i_core_clk) begin
        if (reset_all) begin
            adc_cfg_r  <= `REG8_RESET;
            dac_cfg_r  <= `REG8_RESET;
            gpo_cfg_r  <= `REG8_RESET;
            gpi_cfg_r  <= `REG8_RESET;
            gpo_data_r <= `REG8_RESET;
        end else if (cfg_wr) begin
            if (!locked) begin                                   // RQ24
                case (idx)
                    `REG_ADC_CFG: adc_cfg_r <= i_wr_data[NUM_CH-1:0];
                    `REG_DAC_CFG: dac_cfg_r <= i_wr_data[NUM_CH-1:0];
                    `REG_GPO_CFG: gpo_cfg_r <= i_wr_data[NUM_CH-1:0]; // RQ13
                    `REG_GPI_CFG: gpi_cfg_r <= i_wr_data[NUM_CH-1:0]; // RQ13
                    default: ;
                endcase
            end
            if (idx == `REG_GPO_DATA) begin
                gpo_data_r <= i_wr_data[NUM_CH-1:0];             // RQ14
            end
        end
    end

    // dac input and output registers
    always_ff @(posedge i_core_clk) begin
        if (reset_all) begin
            for (int c = 0; c < NUM_CH; c++) begin
                dac_in_r[c]  <= '0;
                dac_out_r[c] <= '0;
            end
        end else if (load_all) begin
            for (int c = 0; c < NUM_CH; c++) begin
                dac_out_r[c] <= dac_in_r[c];                     // RQ4
            end
        end else if (dac_wr) begin
            dac_in_r[wr_ch] <= i_wr_data[11:0];                  // RQ2
            if (defer_r != `DEFER_HOLD) begin
                dac_out_r[wr_ch] <= i_wr_data[11:0];             // RQ3 RQ27
            end
        end
    end

    // adc sequencer
    assign trk_done   = trk_cnt_r >= 8'(ACQ_CYC);                // RQ7
    assign conv_start = seq_state_r == SEQ_TRACK && trk_done &&
                        (i_rd_addr_ack || start_pend_r);         // RQ8
    assign conv_len   = (cur_ch_r == `TEMP_CHAN_ID) ? 8'(TEMP_CYC)
                                                    : 8'(CONV_CYC);
    assign conv_end   = seq_state_r == SEQ_CONVERT &&
                        conv_cnt_r == conv_len - 8'h01;          // RQ9

    always_ff @(posedge i_core_clk) begin
        if (reset_all) begin
            adc_seq_r <= '0;
        end else if (seq_wr) begin
            adc_seq_r <= i_wr_data[8:0];                         // RQ5 RQ25
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (reset_all) begin
            seq_state_r <= SEQ_IDLE;
            cur_ch_r    <= '0;
            trk_cnt_r   <= '0;
            conv_cnt_r  <= '0;
        end else if (seq_wr) begin
            trk_cnt_r  <= '0;
            conv_cnt_r <= '0;
            if (i_wr_data[8:0] != 9'h000) begin
                seq_state_r <= SEQ_TRACK;                        // RQ6
                cur_ch_r    <= next_chan(i_wr_data[8:0], `TEMP_CHAN_ID);
            end else begin
                seq_state_r <= SEQ_IDLE;
            end
        end else begin
            case (seq_state_r)
                SEQ_TRACK: begin
                    if (conv_start) begin
                        seq_state_r <= SEQ_CONVERT;
                        conv_cnt_r  <= '0;
                    end else if (!trk_done) begin
                        trk_cnt_r <= trk_cnt_r + 8'h01;
                    end
                end
                SEQ_CONVERT: begin
                    if (conv_end) begin
                        seq_state_r <= SEQ_TRACK;
                        trk_cnt_r   <= '0;
                        cur_ch_r    <= next_chan(adc_seq_r, cur_ch_r); // RQ9
                    end else begin
                        conv_cnt_r <= conv_cnt_r + 8'h01;
                    end
                end
                default: seq_state_r <= SEQ_IDLE;
            endcase
        end
    end

    // an ack that arrives early is kept until tracking is long enough
    always_ff @(posedge i_core_clk) begin
        if (reset_all || seq_wr) begin
            start_pend_r <= 1'b0;
        end else if (seq_state_r != SEQ_IDLE) begin
            start_pend_r <= i_rd_addr_ack | (start_pend_r & ~conv_start);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (reset_all) begin
            adc_res_r <= '0;
        end else if (conv_end) begin
            adc_res_r <= {cur_ch_r, i_adc_code};                 // RQ11 RQ26
        end
    end

    // readback pointer and data word
    always_ff @(posedge i_core_clk) begin
        if (reset_all) begin
            rd_ptr_r <= '0;
        end else if (i_ptr_valid) begin
            rd_ptr_r <= i_ptr;                                   // RQ22
        end
    end

    always_comb begin
        rd_data_nxt = '0;
        case (rd_ptr_r[7:4])
            `MODE_ADC_RB: rd_data_nxt = adc_res_r;
            `MODE_DAC_RB: rd_data_nxt = {1'b1, rd_ptr_r[2:0],
                                         dac_out_r[rd_ptr_r[2:0]]};
            `MODE_GPIO_RB: rd_data_nxt = 16'(i_pin_in & gpi_cfg_r); // RQ16
            `MODE_REG_RB: begin
                case (rd_ptr_r[3:0])
                    `REG_ADC_SEQ:  rd_data_nxt = 16'(adc_seq_r);
                    `REG_GP_CTRL:  rd_data_nxt = gp_ctrl_r;
                    `REG_ADC_CFG:  rd_data_nxt = 16'(adc_cfg_r);
                    `REG_DAC_CFG:  rd_data_nxt = 16'(dac_cfg_r);
                    `REG_DEFER:    rd_data_nxt = 16'(defer_r);
                    `REG_GPO_CFG:  rd_data_nxt = 16'(gpo_cfg_r);
                    `REG_GPO_DATA: rd_data_nxt = 16'(gpo_data_r);
                    `REG_GPI_CFG:  rd_data_nxt = 16'(gpi_cfg_r);
                    `REG_PD_REF:   rd_data_nxt = pd_ref_r;
                    default:       rd_data_nxt = '0;
                endcase
            end
            default: rd_data_nxt = '0;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (reset_all) begin
            o_rd_data <= '0;
        end else begin
            o_rd_data <= rd_data_nxt;
        end
    end

    // pin and analog controls; dac wins over gpio drive
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            o_dac_code[c*12 +: 12] = dac_out_r[c];
        end
    end

    assign o_dac_en       = dac_cfg_r;                           // RQ12
    assign o_pin_oe       = gpo_cfg_r & ~dac_cfg_r;              // RQ12 RQ13
    assign o_pin_out      = gpo_data_r & o_pin_oe;               // RQ14
    assign o_pin_pulldown = ~(dac_cfg_r | adc_cfg_r | gpo_cfg_r |
                              gpi_cfg_r);                        // RQ18
    assign o_dac_gain2    = gp_ctrl_r[`GP_DAC_RANGE_BIT];        // RQ1
    assign o_adc_gain2    = gp_ctrl_r[`GP_ADC_RANGE_BIT];        // RQ10
    assign o_ref_en       = pd_ref_r[`PD_REF_EN_BIT];            // RQ17
    assign o_adc_mux      = cur_ch_r;
    assign o_adc_track    = seq_state_r == SEQ_TRACK;
    assign o_adc_convert  = seq_state_r == SEQ_CONVERT;

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    dac_range_a: assert property ( // RQ1
        cfg_wr && idx == `REG_GP_CTRL && !reset_all |=>
        o_dac_gain2 == $past(i_wr_data[`GP_DAC_RANGE_BIT]))
        else $error("dac range bit not applied");

    adc_range_a: assert property ( // RQ10
        cfg_wr && idx == `REG_GP_CTRL && !reset_all |=>
        o_adc_gain2 == $past(i_wr_data[`GP_ADC_RANGE_BIT]))
        else $error("adc range bit not applied");

    dac_immediate_a: assert property ( // RQ3
        dac_wr && defer_r != `DEFER_HOLD && !reset_all |=>
        o_dac_code[$past(wr_ch)*12 +: 12] == $past(i_wr_data[11:0]))
        else $error("dac write did not reach output");

    dac_defer_a: assert property ( // RQ4
        dac_wr && defer_r == `DEFER_HOLD && !reset_all |=>
        $stable(o_dac_code))
        else $error("deferred dac write changed output");

    seq_track_a: assert property ( // RQ6
        seq_wr && i_wr_data[8:0] != 9'h000 && !reset_all |=>
        o_adc_track && trk_cnt_r == 8'h00 &&
        o_adc_mux == next_chan($past(i_wr_data[8:0]), `TEMP_CHAN_ID))
        else $error("sequence write did not start tracking");

    acq_time_a: assert property ( // RQ7
        $rose(o_adc_convert) |-> $past(o_adc_track, 5) &&
        $past(o_adc_track, 1))
        else $error("conversion started before acquisition");

    conv_start_a: assert property ( // RQ8
        o_adc_track && trk_done && i_rd_addr_ack && !reset_all && !seq_wr
        |=> o_adc_convert)
        else $error("ack did not start conversion");

    conv_len_a: assert property ( // RQ9
        $fell(o_adc_convert) && !$past(reset_all) && !$past(seq_wr) |->
        $past(conv_cnt_r) == $past(conv_len) - 8'h01 && o_adc_track)
        else $error("conversion length wrong");

    result_id_a: assert property ( // RQ26
        conv_end && !reset_all && !seq_wr |=>
        adc_res_r == {$past(cur_ch_r), $past(i_adc_code)})
        else $error("adc result word wrong");

    gpio_rb_a: assert property ( // RQ16
        rd_ptr_r[7:4] == `MODE_GPIO_RB && !i_ptr_valid && !reset_all |=>
        o_rd_data == 16'($past(i_pin_in & gpi_cfg_r)))
        else $error("gpio readback wrong");

    cfg_lock_a: assert property ( // RQ24
        cfg_wr && locked && idx == `REG_DAC_CFG && !reset_all |=>
        $stable(o_dac_en))
        else $error("locked configuration changed");

    soft_reset_a: assert property ( // RQ21
        sw_key |=> !o_ref_en && o_pin_oe == '0 && &o_pin_pulldown &&
        !o_adc_track && !o_adc_convert)
        else $error("software reset incomplete");

    pin_reset_a: assert property ( // RQ18
        pin_fall |=> gp_ctrl_r == `REG16_RESET && o_dac_en == '0 &&
        &o_pin_pulldown)
        else $error("reset pin did not restore defaults");

    seq_run_c:   cover property (seq_wr ##[1:40] $fell(o_adc_convert));
    defer_c:     cover property (dac_wr && defer_r == `DEFER_HOLD
                                 ##[1:20] load_all);
    temp_conv_c: cover property (conv_end && cur_ch_r == `TEMP_CHAN_ID);
    sw_reset_c:  cover property (sw_key);

endmodule : configurable_io_channel_control
`default_nettype wire

// ==== verification/host_model.sv ====
// two-wire bus master model issuing decoded writes, pointers and acks
`timescale 1ns/10ps
`default_nettype none
module host_model #(
    parameter int RECOVER_CYC = 2500
) (
    input  wire logic        i_clk,
    output logic             o_wr_valid,
    output logic      [7:0]  o_wr_ptr,
    output logic      [15:0] o_wr_data,
    output logic             o_ptr_valid,
    output logic      [7:0]  o_ptr,
    output logic             o_rd_addr_ack
);
    initial begin
        o_wr_valid = 1'b0;
        o_wr_ptr = 8'h00;
        o_wr_data = 16'h0000;
        o_ptr_valid = 1'b0;
        o_ptr = 8'h00;
        o_rd_addr_ack = 1'b0;
    end
    // released bytes show their inverse, never the last value
    task automatic write_word(input logic [7:0] p, input logic [15:0] d);
        @(negedge i_clk);
        o_wr_valid = 1'b1;
        o_wr_ptr = p;
        o_wr_data = d;
        @(negedge i_clk);
        o_wr_valid = 1'b0;
        o_wr_ptr = ~p;
        o_wr_data = ~d;
    endtask : write_word
    task automatic soft_reset(input logic [15:0] key);
        write_word(8'h0f, key);
    endtask : soft_reset
    task automatic set_pointer(input logic [7:0] p);
        @(negedge i_clk);
        o_ptr_valid = 1'b1;
        o_ptr = p;
        @(negedge i_clk);
        o_ptr_valid = 1'b0;
        o_ptr = ~p;
    endtask : set_pointer
    task automatic read_ack();
        @(negedge i_clk);
        o_rd_addr_ack = 1'b1;
        @(negedge i_clk);
        o_rd_addr_ack = 1'b0;
    endtask : read_ack
    // no writes until the reset has certainly finished
    task automatic recover();
        repeat (RECOVER_CYC) @(negedge i_clk);
    endtask : recover
endmodule : host_model
`default_nettype wire

// ==== verification/configurable_io_channel_control_bench.sv ====
// self-checking bench of the io channel control block
`timescale 1ns/10ps
`default_nettype none
module configurable_io_channel_control_bench;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        rst_n = 1'b1;
    logic [11:0] adc_in = 12'habc;
    wire  [7:0]  pin_in;
    wire         wr_v, ptr_v, ack;
    wire  [7:0]  wr_p, ptr;
    wire  [15:0] wr_d;
    logic [15:0] rd;
    logic [7:0]  pin_out, oe, pd, dac_en;
    logic [95:0] code;
    logic        dg2, ag2, ref_en, trk, cnv;
    logic [3:0]  mux;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cyc = 0;
    int          n;
    // rows: pointer, data, expected {ref, adc gain, dac gain, oe}
    logic [39:0] rows [9] = '{40'h03_0010_0100, 40'h03_0030_0300,
        40'h0b_0200_0700, 40'h08_00f0_07f0, 40'h05_0030_07c0,
        40'h03_00b0_07c0, 40'h08_00ff_07c0, 40'h03_0000_04c0,
        40'h08_000f_040f};
    // driven pins read back their own level, others see an outside pattern
    assign pin_in = (pin_out & oe) | (8'h5a & ~oe);
    initial begin
        forever #50 clk = ~clk;
    end
    host_model host (.i_clk(clk), .o_wr_valid(wr_v), .o_wr_ptr(wr_p),
        .o_wr_data(wr_d), .o_ptr_valid(ptr_v), .o_ptr(ptr),
        .o_rd_addr_ack(ack));
    configurable_io_channel_control #(.NUM_CH(8)) dut (
        .i_core_clk(clk), .i_srst(srst), .i_reset_pin_n(rst_n),
        .i_wr_valid(wr_v), .i_wr_ptr(wr_p), .i_wr_data(wr_d),
        .i_ptr_valid(ptr_v), .i_ptr(ptr), .i_rd_addr_ack(ack),
        .o_rd_data(rd), .i_pin_in(pin_in), .o_pin_out(pin_out),
        .o_pin_oe(oe), .o_pin_pulldown(pd), .o_dac_en(dac_en),
        .o_dac_code(code), .o_dac_gain2(dg2), .o_adc_mux(mux),
        .o_adc_track(trk), .o_adc_convert(cnv), .o_adc_gain2(ag2),
        .i_adc_code(adc_in), .o_ref_en(ref_en));
    function automatic logic [15:0] obs();
        return {5'h00, ref_en, ag2, dg2, oe};
    endfunction : obs
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_cnt(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("unexpected at %0t: count %0d", $time, got);
        end
    endtask : chk_cnt
    task automatic fin(input string nm);
        $display("test %s done", nm);
    endtask : fin
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        srst = 1'b0;
        chk({pd, 7'h00, ref_en}, 16'hff00);
        for (int i = 0; i < 9; i++) begin
            host.write_word(rows[i][39:32], rows[i][31:16]);
            chk(obs(), rows[i][15:0]);
        end
        chk({8'h00, dac_en}, 16'h0030);
        fin("config");
        host.write_word(8'h09, 16'h00a5);
        chk({8'h00, pin_out & oe}, 16'h0005);
        host.write_word(8'h0a, 16'h0003);
        host.set_pointer(8'h60);
        repeat (2) @(negedge clk);
        chk(rd, 16'h0001);
        host.set_pointer(8'h78);
        repeat (2) @(negedge clk);
        chk(rd, 16'h000f);
        fin("gpio");
        host.write_word(8'h12, 16'h0fff);
        chk({4'h0, code[35:24]}, 16'h0fff);
        host.write_word(8'h07, 16'h0001);
        host.write_word(8'h13, 16'h0123);
        host.write_word(8'h14, 16'h0456);
        chk({4'h0, code[47:36]}, 16'h0000);
        host.write_word(8'h07, 16'h0002);
        chk({4'h0, code[47:36]}, 16'h0123);
        chk({4'h0, code[59:48]}, 16'h0456);
        chk({4'h0, code[35:24]}, 16'h0fff);
        host.set_pointer(8'h53);
        repeat (2) @(negedge clk);
        chk(rd, 16'hb123);
        fin("dac");
        host.write_word(8'h02, 16'h0024);
        chk({3'h0, trk, mux, 8'h00}, 16'h1200);
        host.read_ack();
        n = 0;
        while (!cnv && n < 30) begin
            @(negedge clk);
            n++;
        end
        chk_cnt(n, 3, 4);
        n = 0;
        while (cnv && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk_cnt(n, 20, 20);
        chk({3'h0, trk, mux, 8'h00}, 16'h1500);
        host.set_pointer(8'h40);
        repeat (2) @(negedge clk);
        chk(rd, 16'h2abc);
        host.write_word(8'h02, 16'h0100);
        chk({12'h000, mux}, 16'h0008);
        // temperature slot converts for longer and carries its own id
        adc_in = 12'h3c5;
        host.read_ack();
        n = 0;
        while (!cnv && n < 30) begin
            @(negedge clk);
            n++;
        end
        chk_cnt(n, 3, 4);
        n = 0;
        while (cnv && n < 80) begin
            @(negedge clk);
            n++;
        end
        chk_cnt(n, 50, 50);
        host.set_pointer(8'h40);
        repeat (2) @(negedge clk);
        chk(rd, 16'h83c5);
        fin("adc");
        host.soft_reset(16'h0dab);
        chk(obs(), 16'h040f);
        host.soft_reset(16'h0dac);
        chk(obs(), 16'h0000);
        chk({pd, trk, 7'h00}, 16'hff00);
        chk({4'h0, code[35:24]}, 16'h0000);
        host.recover();
        fin("soft reset");
        host.write_word(8'h0b, 16'h0200);
        host.write_word(8'h08, 16'h0001);
        rst_n = 1'b0;
        @(negedge clk);
        chk(obs(), 16'h0000);
        chk({pd, 8'h00}, 16'hff00);
        rst_n = 1'b1;
        host.recover();
        fin("reset pin");
        summarize();
    end
endmodule : configurable_io_channel_control_bench
`default_nettype wire
